// ==== hw/lan_power_link_status_regs.sv ====
`timescale 1ns/1ps
`include "lan_power_link_status_regs.svh"
module lan_power_link_status_regs
  import lan_power_link_status_pkg::*;
#(
  parameter int CNT_W = 32
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        ALTERNATE_RESET_N,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  input  wire logic [2:0]  REG_IDX,
  input  wire logic [31:0] REG_WDATA,
  output logic      [31:0] REG_RDATA,
  input  wire logic        RX_DMA_VALID,
  input  wire logic [2:0]  RX_DMA_BYTES,
  input  wire logic        RX_FRAME_START,
  input  wire logic        PKT_MATCH,
  input  wire logic        WAKE_EVENT,
  input  wire logic        PM_STATE_D2D3,
  input  wire logic        PHY_LINK,
  input  wire logic        PHY_SPEED_100,
  input  wire logic        PHY_FULL_DUPLEX,
  output logic             PME_STATUS,
  output logic             PME_OUT,
  output logic             EARLY_RX_FLAG,
  output logic             INTA_REQ,
  output logic             DEEP_POWER_DOWN,
  output logic             CLK_REQUEST_HOLD,
  output logic [1:0]       FLOW_CMD,
  output logic [15:0]      FLOW_THRESHOLD
);
  initial begin
    if (CNT_W < 8 || CNT_W > 32) $error("CNT_W must lie in 8..32");
  end

  // ========================================================================
  // pin synchronisers
  logic [2:0] phy_s;
  logic       alternate_reset_n_s;
  sync_level #(.WIDTH(3)) u_sync_phy (
    .clk (CLK),
    .d   ({PHY_FULL_DUPLEX, PHY_SPEED_100, PHY_LINK}),
    .q   (phy_s)
  );
  sync_level #(.WIDTH(1)) u_sync_alt (
    .clk (CLK),
    .d   (ALTERNATE_RESET_N),
    .q   (alternate_reset_n_s)
  );
  wire alt_rst    = ~alternate_reset_n_s;
  wire link_s     = phy_s[0];
  wire speed_s    = phy_s[1];
  wire duplex_s   = phy_s[2];

  // ========================================================================
  // decode
  wire wr_count    = REG_WR && REG_IDX == `IDX_RX_BYTE_COUNT;
  wire wr_early    = REG_WR && REG_IDX == `IDX_EARLY_RX;
  wire wr_flow     = REG_WR && REG_IDX == `IDX_FLOW_CONTROL;
  wire wr_wake     = REG_WR && REG_IDX == `IDX_WAKE_EVENT;
  wire wr_gctl     = REG_WR && REG_IDX == `IDX_GEN_CONTROL;

  // ========================================================================
  // receive byte count and early receive
  logic [CNT_W-1:0] rx_count_ff;
  logic [15:0]      early_len_ff;
  logic [15:0]      frame_len_ff;
  logic             early_done_ff;
  logic             early_flag_ff;
  wire [CNT_W-1:0]  nxt_rx_count = rx_count_ff + CNT_W'(RX_DMA_BYTES);
  wire [15:0]       nxt_frame_len = frame_len_ff + 16'(RX_DMA_BYTES);
  // a zero threshold disables the early interrupt
  wire early_hit = RX_DMA_VALID && !early_done_ff && early_len_ff != 16'h0000
                   && nxt_frame_len >= early_len_ff;
  wire early_clr = wr_early && REG_WDATA[31];

  always_ff @(posedge CLK) begin
    if (RST) begin
      rx_count_ff <= '0;
    end else if (wr_count) begin
      rx_count_ff <= '0;
    end else if (RX_DMA_VALID) begin
      rx_count_ff <= nxt_rx_count;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      early_len_ff  <= `EARLY_RX_RESET;
      frame_len_ff  <= 16'h0000;
      early_done_ff <= 1'b0;
      early_flag_ff <= 1'b0;
    end else begin
      if (wr_early) early_len_ff <= REG_WDATA[15:0];
      if (RX_FRAME_START) begin
        frame_len_ff  <= 16'h0000;
        early_done_ff <= 1'b0;
      end else if (RX_DMA_VALID) begin
        frame_len_ff  <= nxt_frame_len;
        if (early_hit) early_done_ff <= 1'b1;
      end
      // set wins over a clear in the same cycle
      if (early_hit) early_flag_ff <= 1'b1;
      else if (early_clr) early_flag_ff <= 1'b0;
    end
  end

  // ========================================================================
  // flow control
  logic [31:0] flow_ff;
  always_ff @(posedge CLK) begin
    if (RST) flow_ff <= `FLOW_CTL_RESET;
    else if (wr_flow) flow_ff <= REG_WDATA;
  end

  // ========================================================================
  // wake event indication, kept across the ordinary reset
  logic link_q_ff;
  logic wake_link_ff;
  logic wake_pkt_ff;
  logic wake_pme_ff;
  wire  link_change = link_s != link_q_ff;
  wire  w1c_link = wr_wake && REG_WDATA[`WAKE_LINK_CHANGE_BIT];
  wire  w1c_pkt  = wr_wake && REG_WDATA[`WAKE_PACKET_BIT];
  wire  w1c_pme  = wr_wake && REG_WDATA[`WAKE_PME_BIT];

  always_ff @(posedge CLK) begin
    if (RST) link_q_ff <= 1'b0;
    else link_q_ff <= link_s;
  end

  always_ff @(posedge CLK) begin
    if (alt_rst) begin
      wake_link_ff <= 1'b0;
      wake_pkt_ff  <= 1'b0;
      wake_pme_ff  <= 1'b0;
    end else begin
      wake_link_ff <= link_change | (wake_link_ff & ~w1c_link);
      wake_pkt_ff  <= PKT_MATCH | (wake_pkt_ff & ~w1c_pkt);
      // WAKE_EVENT input only, not link change or packet match; independent of the PME enable
      wake_pme_ff  <= WAKE_EVENT | (wake_pme_ff & ~w1c_pme);
    end
  end

  wire [31:0] wake_rd = {wake_link_ff, 1'b0, wake_pkt_ff, 4'h0,
                         wake_pme_ff, 24'h00_0000};

  // ========================================================================
  // general control and status
  logic [1:0] gctl_ff;
  always_ff @(posedge CLK) begin
    if (RST) gctl_ff <= 2'(`GCTL_RESET);
    else if (wr_gctl) gctl_ff <= REG_WDATA[1:0];
  end
  // link bit taken from the same flop the change detector compares, so flag and bit move together
  wire [7:0] gstat = {5'h00, duplex_s, speed_s, link_q_ff};
  wire [7:0] gctl_rd = {6'h00, gctl_ff};

  // ========================================================================
  // read mux
  logic [31:0] rd_mux;
  always_comb begin
    unique case (REG_IDX)
      `IDX_RX_BYTE_COUNT: rd_mux = 32'(rx_count_ff);
      `IDX_EARLY_RX:      rd_mux = {early_flag_ff, 15'h0000, early_len_ff};
      `IDX_FLOW_CONTROL:  rd_mux = flow_ff;
      `IDX_WAKE_EVENT:    rd_mux = wake_rd;
      `IDX_GEN_CONTROL:   rd_mux = {24'h00_0000, gctl_rd};
      `IDX_GEN_STATUS:    rd_mux = {24'h00_0000, gstat};
      default:            rd_mux = 32'h0000_0000;
    endcase
  end

  // ========================================================================
  // registered outputs
  always_ff @(posedge CLK) begin
    if (RST) begin
      REG_RDATA        <= 32'h0000_0000;
      EARLY_RX_FLAG    <= 1'b0;
      INTA_REQ         <= 1'b0;
      DEEP_POWER_DOWN  <= 1'b0;
      CLK_REQUEST_HOLD <= 1'b0;
      FLOW_CMD         <= 2'h0;
      FLOW_THRESHOLD   <= 16'h0000;
    end else begin
      REG_RDATA        <= REG_RD ? rd_mux : 32'h0000_0000;
      EARLY_RX_FLAG    <= early_flag_ff;
      INTA_REQ         <= early_flag_ff;
      // deep power-down only while parked in D2/D3 with no link
      DEEP_POWER_DOWN  <= gctl_ff[`GCTL_DEEP_PD_BIT] && PM_STATE_D2D3 && !link_s;
      CLK_REQUEST_HOLD <= gctl_ff[`GCTL_CLK_HOLD_BIT];
      FLOW_CMD         <= flow_ff[17:16];
      FLOW_THRESHOLD   <= flow_ff[15:0];
    end
  end

  // pme follows the wake flag; survives ordinary reset with it
  always_ff @(posedge CLK) begin
    if (alt_rst) begin
      PME_STATUS <= 1'b0;
      PME_OUT    <= 1'b0;
    end else begin
      PME_STATUS <= (wake_pme_ff & ~w1c_pme) | WAKE_EVENT;
      PME_OUT    <= (wake_pme_ff & ~w1c_pme) | WAKE_EVENT;
    end
  end
endmodule // lan_power_link_status_regs

// ==== hw/lan_power_link_status_regs.svh ====
`ifndef LAN_POWER_LINK_STATUS_REGS_SVH
`define LAN_POWER_LINK_STATUS_REGS_SVH

// ==========================================================================
// register indices; the map itself prints no offsets, these are local
`define IDX_RX_BYTE_COUNT      3'h0
`define IDX_EARLY_RX           3'h1
`define IDX_FLOW_CONTROL       3'h2
`define IDX_WAKE_EVENT         3'h3
`define IDX_GEN_CONTROL        3'h4
`define IDX_GEN_STATUS         3'h5

// ==========================================================================
// wake event indication fields
`define WAKE_LINK_CHANGE_BIT   31
`define WAKE_UNSUPPORTED_BIT   30
`define WAKE_PACKET_BIT        29
`define WAKE_PME_BIT           24

// ==========================================================================
// general control and status fields
`define GCTL_DEEP_PD_BIT       1
`define GCTL_CLK_HOLD_BIT      0
`define GSTAT_DUPLEX_BIT       2
`define GSTAT_SPEED_BIT        1
`define GSTAT_LINK_BIT         0

// ==========================================================================
// command block status word
`define CB_EARLY_RX_BIT        9

// ==========================================================================
// reset values
`define GCTL_RESET             8'h00
`define FLOW_CTL_RESET         32'h0000_0000
`define EARLY_RX_RESET         16'h0000

`endif

// ==== hw/lan_power_link_status_pkg.sv ====
package lan_power_link_status_pkg;
  typedef enum logic [1:0] {
    FC_OFF,
    FC_ON,
    FC_PAUSE,
    FC_RSVD
  } flow_cmd_t;
endpackage

// ==== hw/sync_level.sv ====
`timescale 1ns/1ps
module sync_level #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  // first stage is read only by the second stage
  logic [WIDTH-1:0] meta_ff;

  always_ff @(posedge clk) begin
    meta_ff <= d;
    q       <= meta_ff;
  end
endmodule // sync_level

// ==== tb/lan_power_link_status_properties.sv ====
`timescale 1ns/1ps
// ==========================================
// port-level checks of the register bank
module lan_power_link_status_properties
  import lan_power_link_status_pkg::*;
#(parameter int CNT_W = 32) (
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        ALTERNATE_RESET_N,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [2:0]  REG_IDX,
  input wire logic [31:0] REG_WDATA,
  input wire logic [31:0] REG_RDATA,
  input wire logic        WAKE_EVENT,
  input wire logic        PME_STATUS,
  input wire logic        PME_OUT,
  input wire logic        EARLY_RX_FLAG,
  input wire logic        INTA_REQ,
  input wire logic        CLK_REQUEST_HOLD,
  input wire logic [1:0]  FLOW_CMD,
  input wire logic [15:0] FLOW_THRESHOLD
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST || !ALTERNATE_RESET_N);
  sequence s_rd_status; REG_RD && REG_IDX == 3'h5 ##1 1'b1; endsequence
  sequence s_pme_clear; REG_WR && REG_IDX == 3'h3 && REG_WDATA[24] && !WAKE_EVENT; endsequence
  a_bit30_zero: assert property ($past(REG_RD && REG_IDX == 3'h3) |-> REG_RDATA[30] == 1'b0)
    else $error("wake bit 30 read as one");
  a_status_rsvd: assert property (s_rd_status |-> REG_RDATA[31:3] == 29'h0)
    else $error("status upper bits not zero");
  a_pme_mirror: assert property ($past(REG_RD && REG_IDX == 3'h3) |-> REG_RDATA[24] == $past(PME_STATUS))
    else $error("wake bit 24 differs from pme status");
  a_wake_sets: assert property (WAKE_EVENT |-> ##[1:3] PME_STATUS && PME_OUT)
    else $error("wake event did not raise pme");
  a_pme_clear: assert property (s_pme_clear |=> !PME_STATUS && !PME_OUT)
    else $error("pme not cleared by write one");
  a_clk_hold: assert property (REG_WR && REG_IDX == 3'h4 |=> ##1 CLK_REQUEST_HOLD == $past(REG_WDATA[0], 2))
    else $error("clock hold does not follow control bit 0");
  a_flow_load: assert property (REG_WR && REG_IDX == 3'h2 |=> ##1 FLOW_CMD == $past(REG_WDATA[17:16], 2)
    && FLOW_THRESHOLD == $past(REG_WDATA[15:0], 2))
    else $error("flow control fields not loaded");
  a_irq_mirror: assert property (INTA_REQ == EARLY_RX_FLAG)
    else $error("interrupt request differs from early flag");
endmodule // lan_power_link_status_properties

bind lan_power_link_status_regs lan_power_link_status_properties #(.CNT_W(CNT_W)) u_props (
  .CLK(CLK), .RST(RST), .ALTERNATE_RESET_N(ALTERNATE_RESET_N), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_IDX(REG_IDX), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .WAKE_EVENT(WAKE_EVENT),
  .PME_STATUS(PME_STATUS), .PME_OUT(PME_OUT), .EARLY_RX_FLAG(EARLY_RX_FLAG), .INTA_REQ(INTA_REQ),
  .CLK_REQUEST_HOLD(CLK_REQUEST_HOLD), .FLOW_CMD(FLOW_CMD), .FLOW_THRESHOLD(FLOW_THRESHOLD));

// ==== tb/host_model.sv ====
`timescale 1ns/1ps
// ==========================================
// host side of the register access
module host_model (
  input  wire logic        clk,
  output logic             wr,
  output logic             rd,
  output logic [2:0]       idx,
  output logic [31:0]      wdata,
  input  wire logic [31:0] rdata
);
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    idx = 3'h0;
    wdata = 32'h0;
  end
  // bits 28..26 of every write forced to zero; deep power-down kept for stations behind a hub
  task automatic write(input logic [2:0] i, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    idx <= i;
    wdata <= d & 32'he3ff_ffff;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic read(input logic [2:0] i, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    idx <= i;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
endmodule // host_model

// ==== tb/tb.sv ====
`timescale 1ns/1ps
// ==========================================
// register bank bench
module tb;
  import lan_power_link_status_pkg::*;
  `define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
  logic CLK, RST, ALTERNATE_RESET_N, REG_WR, REG_RD, RX_DMA_VALID, RX_FRAME_START, PKT_MATCH;
  logic WAKE_EVENT, PM_STATE_D2D3, PHY_LINK, PHY_SPEED_100, PHY_FULL_DUPLEX, PME_STATUS, PME_OUT;
  logic EARLY_RX_FLAG, INTA_REQ, DEEP_POWER_DOWN, CLK_REQUEST_HOLD;
  logic [2:0]  REG_IDX, RX_DMA_BYTES;
  logic [31:0] REG_WDATA, REG_RDATA, d;
  logic [1:0]  FLOW_CMD;
  logic [15:0] FLOW_THRESHOLD;
  int          err_total, n_compared, cycles;
  logic [2:0]  beats [3] = '{3'h7, 3'h5, 3'h2};
  lan_power_link_status_regs u_lan_power_link_status_regs (.*);
  host_model u_host_model (.clk(CLK), .wr(REG_WR), .rd(REG_RD), .idx(REG_IDX), .wdata(REG_WDATA),
    .rdata(REG_RDATA));
  task automatic results();
    if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask
  task automatic rdchk(input logic [2:0] i, input logic [31:0] e);
    u_host_model.read(i, d);
    `CHK("read data", e, d)
  endtask
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      results();
    end
  end
  initial begin
    {RST, ALTERNATE_RESET_N} = 2'b10;
    {RX_DMA_VALID, RX_DMA_BYTES, RX_FRAME_START, PKT_MATCH, WAKE_EVENT, PM_STATE_D2D3} = '0;
    {PHY_LINK, PHY_SPEED_100, PHY_FULL_DUPLEX} = 3'b000;
    cyc(6);
    {RST, ALTERNATE_RESET_N} <= 2'b01;
    cyc(4);
    rdchk(3'h4, 32'h0);
    rdchk(3'h5, 32'h0);
    {PHY_LINK, PHY_SPEED_100, PHY_FULL_DUPLEX} <= 3'b111;
    cyc(6);
    rdchk(3'h5, 32'h7);
    rdchk(3'h3, 32'h8000_0000);
    u_host_model.write(3'h3, 32'h8000_0000);
    rdchk(3'h3, 32'h0);
    @(posedge CLK) PKT_MATCH <= 1'b1;
    @(posedge CLK) PKT_MATCH <= 1'b0;
    rdchk(3'h3, 32'h2000_0000);
    u_host_model.write(3'h3, 32'h2000_0000);
    @(posedge CLK) WAKE_EVENT <= 1'b1;
    @(posedge CLK) WAKE_EVENT <= 1'b0;
    rdchk(3'h3, 32'h0100_0000);
    `CHK("pme pin", 1'b1, PME_OUT)
    @(posedge CLK) RST <= 1'b1;
    @(posedge CLK) RST <= 1'b0;
    cyc(5);
    // link sampler restarts from zero after the soft reset, so link change reappears
    rdchk(3'h3, 32'h8100_0000);
    u_host_model.write(3'h3, 32'h8100_0000);
    rdchk(3'h3, 32'h0);
    `CHK("pme pin", 2'b00, {PME_STATUS, PME_OUT})
    @(posedge CLK) WAKE_EVENT <= 1'b1;
    @(posedge CLK) WAKE_EVENT <= 1'b0;
    ALTERNATE_RESET_N <= 1'b0;
    cyc(4);
    ALTERNATE_RESET_N <= 1'b1;
    cyc(3);
    rdchk(3'h3, 32'h0);
    u_host_model.write(3'h4, 32'h3);
    rdchk(3'h4, 32'h3);
    `CHK("clock hold", 1'b1, CLK_REQUEST_HOLD)
    {PM_STATE_D2D3, PHY_LINK} <= 2'b10;
    cyc(6);
    `CHK("deep power down", 1'b1, DEEP_POWER_DOWN)
    u_host_model.write(3'h5, 32'hff);
    rdchk(3'h5, 32'h6);
    rdchk(3'h6, 32'h0);
    u_host_model.write(3'h2, 32'h0002_0040);
    rdchk(3'h2, 32'h0002_0040);
    `CHK("flow", {2'(FC_PAUSE), 16'h0040}, {FLOW_CMD, FLOW_THRESHOLD})
    u_host_model.write(3'h1, 32'h0000_000a);
    u_host_model.write(3'h0, 32'h0);
    @(posedge CLK) RX_FRAME_START <= 1'b1;
    @(posedge CLK) RX_FRAME_START <= 1'b0;
    foreach (beats[k]) begin
      RX_DMA_VALID <= 1'b1;
      RX_DMA_BYTES <= beats[k];
      @(posedge CLK);
    end
    RX_DMA_VALID <= 1'b0;
    cyc(3);
    `CHK("early rx", 2'b11, {EARLY_RX_FLAG, INTA_REQ})
    rdchk(3'h0, 32'h0000_000e);
    rdchk(3'h1, 32'h8000_000a);
    u_host_model.write(3'h1, 32'h8000_000a);
    rdchk(3'h1, 32'h0000_000a);
    `CHK("interrupt", 1'b0, INTA_REQ)
    results();
  end
endmodule // tb
